// ### src/pip_i2c_port.sv
// I2C target port of the power controller with its register bank
`timescale 1ns/10ps
`default_nettype none
module pip_i2c_port #(
	parameter int unsigned IDX_W = pip_pkg::IDX_W
) (
	input  wire logic                      ref_clk_i,
	input  wire logic                      arst_n_i,
	input  wire logic                      scl_i,
	input  wire logic                      sda_i,
	output logic                           sda_o,
	output logic                           sda_oe_o,
	input  wire logic                      main_supply_low_i,
	output logic                           bus_busy_o,
	output logic                           reg_wr_o,
	output logic [IDX_W-1:0]               reg_idx_o,
	output logic [pip_pkg::BYTE_W-1:0]     reg_wdata_o
);
	import pip_pkg::*;

	localparam int unsigned REGS = 2 ** IDX_W;

	//------------------------------------------------------------
	// Start and stop detection on SDA edges
	//------------------------------------------------------------
	// Clocked by SDA itself so that no sampling rate limits the
	// bus speed; each condition flips a toggle.
	logic start_tgl_q;
	logic start_tgl_d;
	logic stop_tgl_q;
	logic stop_tgl_d;

	always_comb begin
		start_tgl_d = scl_i ? ~start_tgl_q : start_tgl_q;
		stop_tgl_d  = scl_i ? ~stop_tgl_q : stop_tgl_q;
	end

	always_ff @(negedge sda_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			start_tgl_q <= 1'b0;
		end else begin
			start_tgl_q <= start_tgl_d;
		end
	end

	always_ff @(posedge sda_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			stop_tgl_q <= 1'b0;
		end else begin
			stop_tgl_q <= stop_tgl_d;
		end
	end

	//------------------------------------------------------------
	// Link logic on SCL rising edge
	//------------------------------------------------------------
	pip_state_t        state_q;
	pip_state_t        state_d;
	logic [CNT_W-1:0]  cnt_q;
	logic [CNT_W-1:0]  cnt_d;
	logic [BYTE_W-1:0] shift_q;
	logic [BYTE_W-1:0] shift_d;
	logic [BYTE_W-1:0] tx_q;
	logic [BYTE_W-1:0] tx_d;
	logic [IDX_W-1:0]  idx_q;
	logic [IDX_W-1:0]  idx_d;
	logic              ack_q;
	logic              ack_d;
	logic              first_q;
	logic              first_d;
	logic              rd_act_q;
	logic              rd_act_d;
	logic              start_seen_q;
	logic              stop_seen_q;
	logic              ev_tgl_q;
	logic              ev_tgl_d;
	logic              ev_we_q;
	logic              ev_we_d;
	logic [IDX_W-1:0]  ev_idx_q;
	logic [IDX_W-1:0]  ev_idx_d;
	logic [BYTE_W-1:0] ev_data_q;
	logic [BYTE_W-1:0] ev_data_d;
	logic [BYTE_W-1:0] byte_v;
	logic              start_pend;
	logic              stop_pend;
	logic              low_s;
	logic [BYTE_W-1:0] rd_word_q;

	assign start_pend = start_tgl_q ^ start_seen_q;
	assign stop_pend  = stop_tgl_q ^ stop_seen_q;
	assign byte_v     = {shift_q[BYTE_W-2:0], sda_i};

	pip_sync #(
		.WIDTH(1)
	) u_low_sync (
		.clk_i   (scl_i),
		.arst_n_i(arst_n_i),
		.d_i     (main_supply_low_i),
		.q_o     (low_s)
	);

	always_comb begin
		state_d   = state_q;
		cnt_d     = cnt_q;
		shift_d   = shift_q;
		tx_d      = tx_q;
		idx_d     = idx_q;
		ack_d     = 1'b0;
		first_d   = first_q;
		rd_act_d  = rd_act_q;
		ev_tgl_d  = ev_tgl_q;
		ev_we_d   = ev_we_q;
		ev_idx_d  = ev_idx_q;
		ev_data_d = ev_data_q;
		if (start_pend) begin
			// Repeated start lands here too, dropping any partial byte
			state_d  = PIP_ADDR;
			cnt_d    = FIRST_CNT;
			shift_d  = {{(BYTE_W-1){1'b0}}, sda_i};
			rd_act_d = 1'b0;
		end else if (stop_pend) begin
			state_d  = PIP_IDLE;
			cnt_d    = '0;
			rd_act_d = 1'b0;
		end else if (state_q != PIP_IDLE) begin
			if (cnt_q == ACK_SLOT) begin
				cnt_d = '0;
				if (state_q == PIP_READ) begin
					// Same byte again: reads never move the index
					rd_act_d = first_q | (rd_act_q & ~sda_i);
					first_d  = 1'b0;
					tx_d     = rd_word_q;
				end
			end else begin
				cnt_d   = cnt_q + FIRST_CNT;
				shift_d = byte_v;
				if (cnt_q == LAST_BIT) begin
					unique case (state_q)
						PIP_ADDR: begin
							if (byte_v[BYTE_W-1:1] == TARGET_ADR) begin
								ack_d   = 1'b1;
								first_d = (byte_v[0] == DIR_READ);
								state_d = (byte_v[0] == DIR_READ) ? PIP_READ : PIP_INDEX;
							end else begin
								state_d = PIP_IDLE;
								cnt_d   = '0;
							end
						end
						PIP_INDEX: begin
							ack_d    = 1'b1;
							idx_d    = byte_v[IDX_W-1:0];
							ev_tgl_d = ~ev_tgl_q;
							ev_we_d  = 1'b0;
							ev_idx_d = byte_v[IDX_W-1:0];
							state_d  = PIP_WDATA;
						end
						PIP_WDATA: begin
							ack_d     = 1'b1;
							ev_tgl_d  = ~ev_tgl_q;
							ev_we_d   = 1'b1;
							ev_idx_d  = idx_q;
							ev_data_d = byte_v;
							idx_d     = idx_q + 1'b1;
						end
						PIP_READ: begin
							ack_d = 1'b0;
						end
						PIP_IDLE: begin
							ack_d = 1'b0;
						end
					endcase
				end
			end
		end
	end

	always_ff @(posedge scl_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state_q      <= PIP_IDLE;
			cnt_q        <= '0;
			shift_q      <= '0;
			tx_q         <= '0;
			idx_q        <= '0;
			ack_q        <= 1'b0;
			first_q      <= 1'b0;
			rd_act_q     <= 1'b0;
			start_seen_q <= 1'b0;
			stop_seen_q  <= 1'b0;
			ev_tgl_q     <= 1'b0;
			ev_we_q      <= 1'b0;
			ev_idx_q     <= '0;
			ev_data_q    <= '0;
		end else begin
			state_q      <= state_d;
			cnt_q        <= cnt_d;
			shift_q      <= shift_d;
			tx_q         <= tx_d;
			idx_q        <= idx_d;
			ack_q        <= ack_d;
			first_q      <= first_d;
			rd_act_q     <= rd_act_d;
			start_seen_q <= start_tgl_q;
			stop_seen_q  <= stop_tgl_q;
			ev_tgl_q     <= ev_tgl_d;
			ev_we_q      <= ev_we_d;
			ev_idx_q     <= ev_idx_d;
			ev_data_q    <= ev_data_d;
		end
	end

	//------------------------------------------------------------
	// SDA drive on SCL falling edge
	//------------------------------------------------------------
	logic bit_d;
	logic oe_d;

	always_comb begin
		bit_d = 1'b1;
		if (!start_pend && !stop_pend) begin
			if (ack_q) begin
				bit_d = 1'b0;
			end else if (state_q == PIP_READ && rd_act_q && cnt_q < ACK_SLOT) begin
				bit_d = tx_q[3'h7 - cnt_q[2:0]];
			end
		end
		// Open drain: only a low is ever driven
		oe_d = ~bit_d & ~low_s;
	end

	always_ff @(negedge scl_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sda_o    <= 1'b1;
			sda_oe_o <= 1'b0;
		end else begin
			sda_o    <= bit_d;
			sda_oe_o <= oe_d;
		end
	end

	//------------------------------------------------------------
	// Register bank on the reference clock
	//------------------------------------------------------------
	// Byte events reach here in a few reference cycles, well inside
	// the nine SCL periods before the link fields change again.
	logic [EDGE_W-1:0] edge_s;
	logic [EDGE_W-1:0] edge_prev_q;
	logic              ev_edge;
	logic              start_edge;
	logic              stop_edge;
	logic [BYTE_W-1:0] bank_q [REGS];
	logic [BYTE_W-1:0] bank_d [REGS];
	logic [IDX_W-1:0]  rd_idx_q;
	logic [IDX_W-1:0]  rd_idx_d;
	logic [BYTE_W-1:0] rd_word_d;
	logic              busy_d;
	logic              wr_d;
	logic [IDX_W-1:0]  wr_idx_d;
	logic [BYTE_W-1:0] wr_data_d;

	pip_sync #(
		.WIDTH(EDGE_W)
	) u_edge_sync (
		.clk_i   (ref_clk_i),
		.arst_n_i(arst_n_i),
		.d_i     ({ev_tgl_q, start_tgl_q, stop_tgl_q}),
		.q_o     (edge_s)
	);

	assign ev_edge    = edge_s[2] ^ edge_prev_q[2];
	assign start_edge = edge_s[1] ^ edge_prev_q[1];
	assign stop_edge  = edge_s[0] ^ edge_prev_q[0];

	always_comb begin
		bank_d    = bank_q;
		rd_idx_d  = rd_idx_q;
		wr_d      = 1'b0;
		wr_idx_d  = reg_idx_o;
		wr_data_d = reg_wdata_o;
		busy_d    = bus_busy_o;
		if (stop_edge) begin
			busy_d = 1'b0;
		end
		if (start_edge) begin
			busy_d = 1'b1;
		end
		if (ev_edge) begin
			// No operating-mode gate: bank is open in any state
			if (ev_we_q) begin
				bank_d[ev_idx_q] = ev_data_q;
				wr_d             = 1'b1;
				wr_idx_d         = ev_idx_q;
				wr_data_d        = ev_data_q;
				rd_idx_d         = ev_idx_q + 1'b1;
			end else begin
				rd_idx_d = ev_idx_q;
			end
		end
		rd_word_d = bank_q[rd_idx_q];
	end

	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			for (int i = 0; i < REGS; i++) begin
				bank_q[i] <= REG_RST;
			end
			edge_prev_q <= '0;
			rd_idx_q    <= '0;
			rd_word_q   <= REG_RST;
			bus_busy_o  <= 1'b0;
			reg_wr_o    <= 1'b0;
			reg_idx_o   <= '0;
			reg_wdata_o <= '0;
		end else begin
			bank_q      <= bank_d;
			edge_prev_q <= edge_s;
			rd_idx_q    <= rd_idx_d;
			rd_word_q   <= rd_word_d;
			bus_busy_o  <= busy_d;
			reg_wr_o    <= wr_d;
			reg_idx_o   <= wr_idx_d;
			reg_wdata_o <= wr_data_d;
		end
	end

	//------------------------------------------------------------
	// Assertions
	//------------------------------------------------------------
	sequence addr_miss_s;
		!start_pend && !stop_pend && state_q == PIP_ADDR && cnt_q == LAST_BIT &&
			byte_v[BYTE_W-1:1] != TARGET_ADR;
	endsequence

	addr_ignore_a: assert property (
		@(posedge scl_i) disable iff (!arst_n_i)
		addr_miss_s |=> state_q == PIP_IDLE && !ack_q
	) else $error("foreign address not ignored");

	ack_drive_a: assert property (
		@(posedge scl_i) disable iff (!arst_n_i)
		(cnt_q == ACK_SLOT && ack_q && !start_pend && !stop_pend)
			|-> (sda_oe_o == !low_s) && !sda_o
	) else $error("acknowledge not driven low");

	lockout_quiet_a: assert property (
		@(posedge scl_i) disable iff (!arst_n_i)
		low_s |-> !sda_oe_o
	) else $error("SDA driven under supply lockout");

	restart_addr_a: assert property (
		@(posedge scl_i) disable iff (!arst_n_i)
		start_pend |=> state_q == PIP_ADDR && cnt_q == FIRST_CNT && !rd_act_q
	) else $error("start did not restart address");

	stop_idle_a: assert property (
		@(posedge scl_i) disable iff (!arst_n_i)
		(stop_pend && !start_pend) |=> state_q == PIP_IDLE && !ack_q
	) else $error("stop did not close session");

	index_incr_a: assert property (
		@(posedge scl_i) disable iff (!arst_n_i)
		(!start_pend && !stop_pend && state_q == PIP_WDATA && cnt_q == LAST_BIT)
			|=> idx_q == $past(idx_q) + 1'b1 && ack_q
	) else $error("index did not advance after data");

	read_hold_a: assert property (
		@(posedge scl_i) disable iff (!arst_n_i)
		state_q == PIP_READ |=> idx_q == $past(idx_q)
	) else $error("index moved during read");

	read_msb_a: assert property (
		@(posedge scl_i) disable iff (!arst_n_i)
		(state_q == PIP_READ && rd_act_q && cnt_q < ACK_SLOT && !start_pend && !stop_pend)
			|-> sda_o == tx_q[3'h7 - cnt_q[2:0]]
	) else $error("read bit out of order");

	busy_set_a: assert property (
		@(posedge ref_clk_i) disable iff (!arst_n_i)
		start_edge |=> bus_busy_o
	) else $error("bus not busy after start");

	busy_clr_a: assert property (
		@(posedge ref_clk_i) disable iff (!arst_n_i)
		(stop_edge && !start_edge) |=> !bus_busy_o
	) else $error("bus not free after stop");

	write_pulse_a: assert property (
		@(posedge ref_clk_i) disable iff (!arst_n_i)
		reg_wr_o |-> $past(ev_edge) && $past(ev_we_q) ##1 !reg_wr_o
	) else $error("register write without whole byte");
endmodule
`default_nettype wire

// ### src/pip_pkg.sv
// Constants and types shared by the PMIC I2C register port
//------------------------------------------------------------
// Behaviour
// - SDA falling while SCL high is a START opening a session.
// - SDA rising while SCL high is a STOP closing the session.
// - Bus busy from START until STOP, free after STOP.
// - Repeated START acts like START and restarts address reception.
// - Bytes are eight bits, MSB first, each followed by an acknowledge slot.
// - Device pulls SDA low during the ninth clock after each received byte.
// - Under supply lockout the device never drives SDA.
// - First byte is seven-bit address plus direction bit, one means read.
// - Device answers only to address 0x60; others are ignored unacknowledged.
// - In a write, second byte is register index, third is data.
// - Index advances by one after each written data byte.
// - Index does not advance across read bytes.
// - Port works at 100 kHz, 1 MHz and 3.4 MHz bus clock.
// - Every register is readable and writable in standby and active.
//------------------------------------------------------------
package pip_pkg;
	localparam int unsigned BYTE_W     = 8;
	localparam int unsigned IDX_W      = 8;
	localparam int unsigned CNT_W      = 4;
	localparam int unsigned EDGE_W     = 3;
	localparam logic [6:0]  TARGET_ADR = 7'h60;
	localparam logic [3:0]  LAST_BIT   = 4'h7;
	localparam logic [3:0]  ACK_SLOT   = 4'h8;
	localparam logic [3:0]  FIRST_CNT  = 4'h1;
	localparam logic        DIR_READ   = 1'b1;
	localparam logic [7:0]  REG_RST    = 8'h00;

	typedef enum logic [2:0] {
		PIP_IDLE,
		PIP_ADDR,
		PIP_INDEX,
		PIP_WDATA,
		PIP_READ
	} pip_state_t;
endpackage

// ### src/pip_sync.sv
// Two-stage synchroniser for levels and toggles
`timescale 1ns/10ps
`default_nettype none
module pip_sync #(
	parameter int unsigned WIDTH = 1
) (
	input  wire logic             clk_i,
	input  wire logic             arst_n_i,
	input  wire logic [WIDTH-1:0] d_i,
	output logic      [WIDTH-1:0] q_o
);
	logic [WIDTH-1:0] meta_q;

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			meta_q <= '0;
			q_o    <= '0;
		end else begin
			meta_q <= d_i;
			q_o    <= meta_q;
		end
	end
endmodule
`default_nettype wire

// ### tb/pip_i2c_master.sv
// Behavioural I2C bus master facing the register port
`timescale 1ns/10ps
`default_nettype none
module pip_i2c_master #(
	parameter real HALF = 7.5,
	parameter real GAP  = 400.0
) (
	output logic      scl_o,
	output logic      sda_o,
	input  wire logic sda_i
);
	localparam real Q = HALF / 2.0;

	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end

	// Also a repeated START from SCL low
	task automatic start();
		#Q sda_o = 1'b1;
		#Q scl_o = 1'b1;
		#HALF sda_o = 1'b0;
		#HALF scl_o = 1'b0;
	endtask

	// Both lines left high after it
	task automatic stop();
		#Q sda_o = 1'b0;
		#Q scl_o = 1'b1;
		#HALF sda_o = 1'b1;
		#GAP;
	endtask

	// Short n aborts mid-byte; SDA moves only with SCL low
	task automatic send(input logic [7:0] b, input int n, output logic ack);
		ack = 1'b1;
		for (int i = 7; i > 7 - n; i--) begin
			#Q sda_o = b[i];
			#Q scl_o = 1'b1;
			#HALF scl_o = 1'b0;
		end
		if (n == 8) begin
			#Q sda_o = 1'b1;
			#Q scl_o = 1'b1;
			#Q ack = sda_i;
			#Q scl_o = 1'b0;
		end
		#GAP;
	endtask

	// Released SDA in the slot ends the read
	task automatic recv(output logic [7:0] b, input logic nack);
		#Q sda_o = 1'b1;
		for (int i = 0; i < 8; i++) begin
			#HALF scl_o = 1'b1;
			#Q b = {b[6:0], sda_i};
			#Q scl_o = 1'b0;
		end
		#Q sda_o = nack;
		#Q scl_o = 1'b1;
		#HALF scl_o = 1'b0;
		#Q sda_o = 1'b1;
		#GAP;
	endtask
endmodule
`default_nettype wire

// ### tb/pmic_i2c_register_port_tb.sv
// Self-checking bench for the I2C register port
`timescale 1ns/10ps
`default_nettype none
module pmic_i2c_register_port_tb;
	import pip_pkg::*;
	localparam logic [7:0] ADR_WR = {TARGET_ADR, ~DIR_READ};
	localparam logic [7:0] ADR_RD = {TARGET_ADR, DIR_READ};
	logic              ref_clk_i = 1'b0;
	logic              arst_n_i;
	logic              main_supply_low_i = 1'b0;
	logic              scl_w, ms_sda, sda_w, sda_o, sda_oe_o;
	logic              bus_busy_o, reg_wr_o, ack;
	logic [IDX_W-1:0]  reg_idx_o;
	logic [BYTE_W-1:0] reg_wdata_o;
	logic [7:0]        rd, idx, d0, d1;
	logic [15:0]       exp_q[$];
	int                n_mismatch = 0;
	int                tests_run = 0;
	int                cycles = 0;

	always #25 ref_clk_i = ~ref_clk_i;
	// Pull-up: high unless someone pulls low
	assign sda_w = ms_sda & (sda_oe_o ? sda_o : 1'b1);

	pip_i2c_port pip_i2c_port_i (
		.ref_clk_i        (ref_clk_i),
		.arst_n_i         (arst_n_i),
		.scl_i            (scl_w),
		.sda_i            (sda_w),
		.sda_o            (sda_o),
		.sda_oe_o         (sda_oe_o),
		.main_supply_low_i(main_supply_low_i),
		.bus_busy_o       (bus_busy_o),
		.reg_wr_o         (reg_wr_o),
		.reg_idx_o        (reg_idx_o),
		.reg_wdata_o      (reg_wdata_o)
	);
	pip_i2c_master m (
		.scl_o(scl_w),
		.sda_o(ms_sda),
		.sda_i(sda_w)
	);

	task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic close_out();
		$display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Stores are judged by the watcher, not here
	task automatic write2(input logic [7:0] i, input logic [7:0] a, input logic [7:0] b, input logic ak);
		exp_q.push_back({i, a});
		exp_q.push_back({i + 8'h01, b});
		m.start();
		m.send(ADR_WR, 8, ack);
		check("addr ack", 16'(ack), 16'(ak));
		m.send(i, 8, ack);
		check("index ack", 16'(ack), 16'(ak));
		m.send(a, 8, ack);
		check("data ack", 16'(ack), 16'(ak));
		m.send(b, 8, ack);
		check("last ack", 16'(ack), 16'(ak));
		check("busy", 16'(bus_busy_o), 16'h1);
		m.stop();
		check("free", 16'(bus_busy_o), 16'h0);
	endtask

	task automatic read2(input logic [7:0] i, input logic [7:0] e);
		m.start();
		m.send(ADR_WR, 8, ack);
		m.send(i, 8, ack);
		m.start();
		m.send(ADR_RD, 8, ack);
		check("read addr ack", 16'(ack), 16'h0);
		m.recv(rd, 1'b0);
		check("read byte", 16'(rd), 16'(e));
		m.recv(rd, 1'b1);
		check("read again", 16'(rd), 16'(e));
		m.stop();
	endtask

	// Negedge sampling keeps clear of the register updates
	always @(negedge ref_clk_i) begin
		cycles++;
		if (cycles > 6000) begin
			n_mismatch++;
			$display("[ERR] run exceeded its cycle ceiling");
			close_out();
		end else if (reg_wr_o !== 1'b0 && arst_n_i) begin
			if (exp_q.size() == 0)
				check("stray store", 16'(reg_wr_o), 16'h0);
			else
				check("store", {reg_idx_o, reg_wdata_o}, exp_q.pop_front());
		end
	end

	initial begin
		// Reset edge in the NBA region so every async flop sees it
		arst_n_i <= 1'b0;
		void'($urandom(32'hd447));
		repeat (4) @(posedge ref_clk_i);
		arst_n_i <= 1'b1;
		repeat (4) @(posedge ref_clk_i);
		for (int k = 0; k < 4; k++) begin
			// Last pass runs the index over the top of the bank
			idx = (k == 3) ? 8'hff : 8'($urandom);
			d0 = 8'($urandom);
			d1 = 8'($urandom);
			write2(idx, d0, d1, 1'b0);
			read2(idx, d0);
			read2(idx + 8'h01, d1);
			$display("Test write and read %0d done", k);
		end
		m.start();
		m.send({TARGET_ADR ^ 7'h01, 1'b0}, 8, ack);
		check("foreign ack", 16'(ack), 16'h1);
		m.send(8'h10, 8, ack);
		check("ignored ack", 16'(ack), 16'h1);
		m.stop();
		$display("Test foreign address done");
		m.start();
		m.send(ADR_WR, 8, ack);
		m.send(8'h20, 8, ack);
		m.send(8'h5a, 4, ack);
		m.stop();
		m.start();
		m.send(ADR_WR, 8, ack);
		m.send(8'h21, 8, ack);
		m.send(8'ha5, 5, ack);
		m.start();
		m.send(ADR_WR, 8, ack);
		check("restart ack", 16'(ack), 16'h0);
		m.stop();
		$display("Test aborted bytes done");
		@(posedge ref_clk_i);
		main_supply_low_i <= 1'b1;
		write2(8'h40, 8'h3c, 8'hc3, 1'b1);
		// Stored byte must not come back while locked out
		m.start();
		m.send(ADR_WR, 8, ack);
		m.send(8'h40, 8, ack);
		m.start();
		m.send(ADR_RD, 8, ack);
		check("lockout read ack", 16'(ack), 16'h1);
		m.recv(rd, 1'b1);
		check("lockout read", 16'(rd), 16'hff);
		m.stop();
		@(posedge ref_clk_i);
		main_supply_low_i <= 1'b0;
		read2(8'h41, 8'hc3);
		$display("Test supply lockout done");
		repeat (20) @(posedge ref_clk_i);
		check("pending stores", 16'(exp_q.size()), 16'h0);
		close_out();
	end
endmodule
`default_nettype wire
